/* File: verilog/pdbc_ctrl.sv */
// module: read buffering control register and its policy outputs
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - park bit: 0 last master, 1 bridge
// - bit1 set disables dynamic prefetch control
// - bit2 set disables completion data prediction
// - bit3 converts type0 to type1 when top nibble ones
// - conversion forces address bit 0 to 1, type 1
// - read multiple 00 one line, reset 10
// - mode 01 full, keep data after disconnect
// - mode 11 keeps after any end; 10 full
// - read line field same encodings, reset 00
// - plain read field, 00 one line
module pdbc_ctrl
	import pdbc_pkg::*;
(
	// clock and reset
	input  wire logic         ref_clk_i,
	input  wire logic         rst_b_i,
	// register port
	input  wire logic [7:0]   reg_addr_i,
	input  wire logic [31:0]  reg_wdata_i,
	input  wire logic         reg_wr_i,
	input  wire logic         reg_rd_i,
	output logic      [31:0]  reg_rdata_o,
	// arbiter and completion policy
	output logic              park_bridge_o,
	output logic              dyn_ctrl_en_o,
	output logic              pred_en_o,
	// configuration conversion
	input  wire logic         cfg_valid_i,
	input  wire logic [31:0]  cfg_addr_i,
	output logic              cfg_type1_o,
	output logic [31:0]       cfg_addr_o,
	// read request and termination
	input  wire pdbc_rd_req_t rd_req_i,
	input  wire logic         rd_disc_i,
	input  wire logic         rd_end_i,
	input  wire logic         rd_hit_i,
	input  wire logic         discard_exp_i,
	output logic              pf_full_o,
	output logic              refetch_o,
	output logic              ret_held_o
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [31:0]     ctrl;
		logic [31:0]     rdata;
		logic            park;
		logic            dyn;
		logic            pred;
		logic            type1;
		logic [31:0]     caddr;
		logic            full;
		logic            refetch;
		pdbc_ret_state_t ret;
		logic            keep_disc;
		logic            keep_end;
	} pdbc_state_t;

	pdbc_state_t  st_reg;
	pdbc_state_t  st_next;
	logic [1:0]   mode_sel;
	pdbc_pf_dec_t dec;

	// ==========================================================
	// mode select per command
	always_comb
	begin
		if (rd_req_i.cmd == PDBC_CMD_MRM)
			mode_sel = st_reg.ctrl[PDBC_LSB_RDMUL +: 2];
		else if (rd_req_i.cmd == PDBC_CMD_MRL)
			mode_sel = st_reg.ctrl[PDBC_LSB_RDLINE +: 2];
		else
			mode_sel = st_reg.ctrl[PDBC_LSB_RDPLAIN +: 2];
	end

	pdbc_pf_decode u_dec (
		.mode_i         (mode_sel),
		.prefetchable_i (rd_req_i.prefetchable),
		.dec_o          (dec)
	);

	// ==========================================================
	// next state
	always_comb
	begin
		st_next         = st_reg;
		st_next.refetch = 1'b0;
		st_next.rdata   = '0;
		if (reg_wr_i && (reg_addr_i == PDBC_OFF_CTRL))
			st_next.ctrl = reg_wdata_i & PDBC_CTRL_WMASK;
		if (reg_rd_i && (reg_addr_i == PDBC_OFF_CTRL))
			st_next.rdata = st_reg.ctrl;
		st_next.park = st_reg.ctrl[PDBC_BIT_PARK];
		st_next.dyn  = ~st_reg.ctrl[PDBC_BIT_DYNDIS];
		st_next.pred = ~st_reg.ctrl[PDBC_BIT_PREDDIS];
		if (cfg_valid_i)
		begin
			st_next.caddr = cfg_addr_i;
			st_next.type1 = 1'b0;
			if (st_reg.ctrl[PDBC_BIT_CFGCONV] && (cfg_addr_i[31:28] == PDBC_CFG_TOP))
			begin
				st_next.type1    = 1'b1;
				st_next.caddr[0] = 1'b1;
			end
		end
		if (rd_req_i.valid)
		begin
			st_next.full = dec.full;
			if (st_reg.ret == PDBC_RET_EMPTY || !rd_hit_i)
			begin
				st_next.refetch   = 1'b1;
				st_next.ret       = PDBC_RET_EMPTY;
				st_next.keep_disc = dec.keep_on_disc;
				st_next.keep_end  = dec.keep_on_end;
			end
		end
		case (st_reg.ret)
			PDBC_RET_EMPTY:
			begin
				if ((rd_disc_i && st_reg.keep_disc) || (rd_end_i && st_reg.keep_end))
					st_next.ret = PDBC_RET_HELD;
			end
			PDBC_RET_HELD:
			begin
				if (discard_exp_i)
					st_next.ret = PDBC_RET_EMPTY;
			end
			default:
			begin
				st_next.ret = PDBC_RET_EMPTY;
			end
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
		begin
			st_reg       <= '0;
			st_reg.ctrl  <= PDBC_CTRL_RESET;
			st_reg.dyn   <= 1'b1;
			st_reg.pred  <= 1'b1;
			st_reg.ret   <= PDBC_RET_EMPTY;
		end
		else
			st_reg <= st_next;
	end

	assign reg_rdata_o   = st_reg.rdata;
	assign park_bridge_o = st_reg.park;
	assign dyn_ctrl_en_o = st_reg.dyn;
	assign pred_en_o     = st_reg.pred;
	assign cfg_type1_o   = st_reg.type1;
	assign cfg_addr_o    = st_reg.caddr;
	assign pf_full_o     = st_reg.full;
	assign refetch_o     = st_reg.refetch;
	assign ret_held_o    = (st_reg.ret == PDBC_RET_HELD);

	// ==========================================================
	// checks
	AST_PARK: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		park_bridge_o == $past(st_reg.ctrl[PDBC_BIT_PARK]))
		else $error("park select mismatch");
	AST_DYN: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == PDBC_OFF_CTRL |-> ##2 dyn_ctrl_en_o == !$past(reg_wdata_i[1], 2))
		else $error("dynamic control mismatch");
	AST_PRED: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == PDBC_OFF_CTRL |-> ##2 pred_en_o == !$past(reg_wdata_i[2], 2))
		else $error("prediction mismatch");
	AST_CONV: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		cfg_valid_i |=> cfg_type1_o == ($past(st_reg.ctrl[3]) && $past(cfg_addr_i[31:28]) == 4'hf))
		else $error("conversion decision wrong");
	AST_AD0: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		cfg_type1_o |-> cfg_addr_o[0])
		else $error("converted access not type 1");
	AST_MUL_LINE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		rd_req_i.valid && rd_req_i.cmd == PDBC_CMD_MRM && st_reg.ctrl[5:4] == 2'h0 |=> !pf_full_o)
		else $error("read multiple 00 prefetched fully");
	AST_LINE_FULL: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		rd_req_i.valid && rd_req_i.cmd == PDBC_CMD_MRL && rd_req_i.prefetchable
		&& st_reg.ctrl[7:6] != 2'h0 |=> pf_full_o)
		else $error("read line full prefetch missing");
	AST_PLAIN: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		rd_req_i.valid && rd_req_i.cmd == PDBC_CMD_MR && st_reg.ctrl[9:8] == 2'h0 |=> !pf_full_o)
		else $error("plain read 00 prefetched fully");
	AST_KEEP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		!ret_held_o && rd_end_i && st_reg.keep_end |=> ret_held_o)
		else $error("data not kept after end");
	AST_EXPIRE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		ret_held_o && discard_exp_i |=> !ret_held_o)
		else $error("retained data survived expiry");
endmodule : pdbc_ctrl
`default_nettype wire

/* File: verilog/pdbc_pkg.sv */
// package: register map, field layout and encodings of the read buffering control block
package pdbc_pkg;
	// ==========================================================
	// register map
	localparam logic [7:0]  PDBC_OFF_CTRL    = 8'h40;
	localparam logic [31:0] PDBC_CTRL_RESET  = 32'h0000_0020;
	localparam logic [31:0] PDBC_CTRL_WMASK  = 32'h0000_03ff;
	localparam int          PDBC_BIT_PARK    = 0;
	localparam int          PDBC_BIT_DYNDIS  = 1;
	localparam int          PDBC_BIT_PREDDIS = 2;
	localparam int          PDBC_BIT_CFGCONV = 3;
	localparam int          PDBC_LSB_RDMUL   = 4;
	localparam int          PDBC_LSB_RDLINE  = 6;
	localparam int          PDBC_LSB_RDPLAIN = 8;
	localparam logic [3:0]  PDBC_CFG_TOP     = 4'hf;

	// ==========================================================
	// prefetch modes
	typedef enum logic [1:0] {
		PDBC_PF_LINE    = 2'h0,
		PDBC_PF_KEEPDIS = 2'h1,
		PDBC_PF_FULL    = 2'h2,
		PDBC_PF_KEEPALL = 2'h3
	} pdbc_pf_mode_t;

	// ==========================================================
	// read command kinds
	localparam logic [1:0] PDBC_CMD_MR  = 2'h0;
	localparam logic [1:0] PDBC_CMD_MRL = 2'h1;
	localparam logic [1:0] PDBC_CMD_MRM = 2'h2;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic        valid;
		logic [1:0]  cmd;
		logic        prefetchable;
	} pdbc_rd_req_t;

	typedef struct packed {
		logic        full;
		logic        keep_on_disc;
		logic        keep_on_end;
	} pdbc_pf_dec_t;

	// retained data states, one-hot
	typedef enum logic [1:0] {
		PDBC_RET_EMPTY = 2'b01,
		PDBC_RET_HELD  = 2'b10
	} pdbc_ret_state_t;
endpackage : pdbc_pkg

/* File: verilog/pdbc_pf_decode.sv */
// module: decode of one prefetch mode field
`timescale 1ns/1ps
`default_nettype none
module pdbc_pf_decode
	import pdbc_pkg::*;
(
	// mode in
	input  wire logic [1:0]   mode_i,
	input  wire logic         prefetchable_i,
	// decode out
	output pdbc_pf_dec_t      dec_o
);
	always_comb
	begin
		dec_o              = '0;
		dec_o.full         = prefetchable_i && (mode_i != PDBC_PF_LINE);
		dec_o.keep_on_disc = prefetchable_i && ((mode_i == PDBC_PF_KEEPDIS)
			|| (mode_i == PDBC_PF_KEEPALL));
		dec_o.keep_on_end  = prefetchable_i && (mode_i == PDBC_PF_KEEPALL);
	end
endmodule : pdbc_pf_decode
`default_nettype wire

/* File: test/pdbc_pci_master.sv */
// pci master model on the secondary bus
`timescale 1ns/1ps
`default_nettype none
module pdbc_pci_master
	import pdbc_pkg::*;
(
	// clock
	input  wire logic    ref_clk_i,
	// read traffic
	output pdbc_rd_req_t rq_o,
	output logic         disc_o,
	output logic         end_o,
	output logic         hit_o,
	output logic         exp_o,
	// config traffic
	output logic         cv_o,
	output logic [31:0]  ca_o
);
	initial
	begin
		rq_o = '0;
		{disc_o, end_o, hit_o, exp_o, cv_o} = '0;
		ca_o = '0;
	end
	// ===
	// one read request, h says whether it hits the retained data
	task read(input logic [1:0] c, input logic p, input logic h);
		@(posedge ref_clk_i) {rq_o, hit_o} <= {1'b1, c, p, h};
		@(posedge ref_clk_i) {rq_o.valid, hit_o} <= 2'h0;
	endtask : read
	// ===
	// 0 disconnect, 1 end, 2 timer expiry
	task term(input int k);
		@(posedge ref_clk_i) {disc_o, end_o, exp_o} <= {k == 0, k == 1, k == 2};
		@(posedge ref_clk_i) {disc_o, end_o, exp_o} <= 3'h0;
	endtask : term
	// ===
	// config address, other bits in type 1 format
	task cfg(input logic [31:0] a);
		@(posedge ref_clk_i) {cv_o, ca_o} <= {1'b1, a};
		@(posedge ref_clk_i) cv_o <= 1'b0;
	endtask : cfg
endmodule : pdbc_pci_master
`default_nettype wire

/* File: test/pci_read_buffering_control_test.sv */
// bench of the read buffering control register
`timescale 1ns/1ps
`default_nettype none
module pci_read_buffering_control_test
	import pdbc_pkg::*;
();
	logic clk, rst_b, wr, rd, park, dyn, pred, ct1, pff, rf, held;
	logic [7:0] addr;
	logic [31:0] wd, rdat, ca, d, a;
	logic t;
	int error_cnt, compares;
	pdbc_rd_req_t rq;
	logic disc, rend, hit, dexp, cv;
	logic [31:0] cao;
	pdbc_pci_master u_pm (.ref_clk_i(clk), .rq_o(rq), .disc_o(disc), .end_o(rend),
		.hit_o(hit), .exp_o(dexp), .cv_o(cv), .ca_o(ca));
	pdbc_ctrl u_dut (.ref_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wd),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .park_bridge_o(park),
		.dyn_ctrl_en_o(dyn), .pred_en_o(pred), .cfg_valid_i(cv), .cfg_addr_i(ca),
		.cfg_type1_o(ct1), .cfg_addr_o(cao), .rd_req_i(rq), .rd_disc_i(disc),
		.rd_end_i(rend), .rd_hit_i(hit), .discard_exp_i(dexp), .pf_full_o(pff),
		.refetch_o(rf), .ret_held_o(held));
	// ===
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task wr_reg(input logic [7:0] ad, input logic [31:0] v);
		@(posedge clk) {wr, addr, wd} <= {1'b1, ad, v};
		@(posedge clk) wr <= 1'b0;
	endtask : wr_reg
	task rd_reg(input logic [7:0] ad, input logic [31:0] e);
		@(posedge clk) {rd, addr} <= {1'b1, ad};
		@(posedge clk) rd <= 1'b0;
		@(negedge clk) chk("rdata", rdat, e);
		@(negedge clk) chk("rdata_idle", rdat, 32'h0);
	endtask : rd_reg
	task summarize;
		$display("counts: %0d compares, %0d errors", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize
	// ===
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		summarize();
	end
	initial
	begin
		{rst_b, wr, rd, addr, wd} = '0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		void'($urandom(70186));
		rd_reg(PDBC_OFF_CTRL, PDBC_CTRL_RESET);
		chk("park", park, 32'h0);
		chk("dyn", dyn, 32'h1);
		chk("pred", pred, 32'h1);
		$display("test reset done");
		for (int i = 0; i < 20; i++)
		begin
			d = (i < 2) ? {32{i[0]}} : $urandom;
			wr_reg(PDBC_OFF_CTRL, d);
			wr_reg(8'h44, ~d);
			rd_reg(PDBC_OFF_CTRL, d & PDBC_CTRL_WMASK);
			chk("park", park, d[0]);
			chk("dyn", dyn, !d[1]);
			chk("pred", pred, !d[2]);
			rd_reg(8'h44, 32'h0);
		end
		$display("test registers done");
		for (int i = 0; i < 8; i++)
		begin
			a = $urandom;
			a[31:28] = i[1] ? PDBC_CFG_TOP : 4'(i);
			wr_reg(PDBC_OFF_CTRL, {28'h0, i[0], 3'h0});
			u_pm.cfg(a);
			@(negedge clk);
			t = i[0] && a[31:28] == 4'hf;
			chk("type1", ct1, t);
			chk("cfg_addr", cao, t ? a | 32'h1 : a);
		end
		$display("test conversion done");
		for (int c = 0; c < 3; c++)
			for (int m = 0; m < 4; m++)
			begin
				t = $urandom;
				wr_reg(PDBC_OFF_CTRL, 32'(m) << (8 - 2 * c));
				u_pm.read(2'(c), t, 1'b0);
				@(negedge clk) chk("pf_full", pff, t && m != 0);
				chk("refetch", rf, 32'h1);
				u_pm.term(0);
				@(negedge clk) chk("held_disc", held, t && m[0]);
				u_pm.read(2'(c), t, 1'b1);
				@(negedge clk) chk("refetch_hit", rf, !(t && m[0]));
				u_pm.term(2);
				@(negedge clk) chk("held_exp", held, 32'h0);
				u_pm.read(2'(c), t, 1'b0);
				u_pm.term(1);
				@(negedge clk) chk("held_end", held, t && m == 3);
				u_pm.term(2);
			end
		$display("test prefetch done");
		summarize();
	end
endmodule : pci_read_buffering_control_test
`default_nettype wire
